// file: common/ibb_defines.svh
// Constants for the instruction byte buffer: register map, fields, reset values
`ifndef IBB_DEFINES_SVH
`define IBB_DEFINES_SVH

// ==========================================
// Register bus
`define IBB_ADDR_W 4
`define IBB_CTRL_OFF 4'h0
`define IBB_STATUS_OFF 4'h4
`define IBB_RESP_OKAY 2'h0
`define IBB_RESP_DECERR 2'h3

// ==========================================
// Register fields
`define IBB_CTRL_IRQ_BIT 0
`define IBB_CTRL_FLUSH_BIT 1
`define IBB_ST_PTR_LSB 0
`define IBB_ST_HEAD_LSB 8
`define IBB_ST_EVEN_LSB 16
`define IBB_ST_ODD_LSB 24

// ==========================================
// Widths and reset values
`define IBB_BYTE_W 8
`define IBB_NIB_W 4
`define IBB_BYTE_RST 8'h00
`define IBB_WORD_RST 16'h0000
`define IBB_DATA_RST 32'h00000000

`endif

// file: common/ibb_pkg.sv
// Types shared by the instruction byte buffer modules
`default_nettype none
package ibb_pkg;
	// Occupancy pointer, gray coded, stepped 2,3,1,0 on reads
	typedef enum logic [1:0] {
		IBB_PTR_EMPTY = 2'b00,
		IBB_PTR_BYTE = 2'b01,
		IBB_PTR_FULL = 2'b10,
		IBB_PTR_WORD = 2'b11
	} ibb_ptr_e;

	// Operation handed from the control side to the buffer core
	typedef enum logic [2:0] {
		IBB_OP_NONE = 3'b000,
		IBB_OP_LOAD = 3'b001,
		IBB_OP_LOAD_ODD = 3'b010,
		IBB_OP_ADVANCE = 3'b011,
		IBB_OP_SEL_EVEN = 3'b100,
		IBB_OP_SEL_ODD = 3'b101,
		IBB_OP_FLUSH = 3'b110
	} ibb_op_e;

	// Register decode result
	typedef enum logic [1:0] {
		IBB_REG_CTRL = 2'b00,
		IBB_REG_STATUS = 2'b01,
		IBB_REG_NONE = 2'b10
	} ibb_reg_e;
endpackage
`default_nettype wire

// file: common/ibb_if.sv
// Link between the buffer control logic and the byte storage core
`default_nettype none
interface ibb_if;
	import ibb_pkg::*;
	ibb_op_e op;
	logic [15:0] xin;
	ibb_ptr_e ptr;
	logic [7:0] head;
	logic [7:0] even;
	logic [7:0] odd;

	modport core (input op, input xin, output ptr, output head, output even, output odd);
	modport ctl (output op, output xin, input ptr, input head, input even, input odd);
endinterface
`default_nettype wire

// file: design/ibb_core.sv
// Byte storage core: even, odd and head registers with the occupancy pointer
`include "ibb_defines.svh"
`default_nettype none
module ibb_core
	import ibb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ibb_if.core bus
);

	typedef struct packed {
		logic [7:0] even;
		logic [7:0] odd;
		logic [7:0] head;
		ibb_ptr_e ptr;
	} ibb_core_s;

	ibb_core_s s_r;
	ibb_core_s s_nxt;

	// Gray decrement of the pointer: 2, 3, 1, 0
	function automatic ibb_ptr_e gray_dec(input ibb_ptr_e p);
		case (p)
			IBB_PTR_FULL: gray_dec = IBB_PTR_WORD;
			IBB_PTR_WORD: gray_dec = IBB_PTR_BYTE;
			IBB_PTR_BYTE: gray_dec = IBB_PTR_EMPTY;
			default: gray_dec = IBB_PTR_FULL;
		endcase
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		case (bus.op)
			IBB_OP_LOAD, IBB_OP_LOAD_ODD: begin
				s_nxt.even = bus.xin[15:8]; // [RULE_14]
				s_nxt.odd = bus.xin[7:0];
				if (s_r.ptr == IBB_PTR_EMPTY) begin
					// Feed-through so the byte is usable next cycle [RULE_15] [RULE_16]
					s_nxt.head = (bus.op == IBB_OP_LOAD) ? bus.xin[15:8] : bus.xin[7:0];
					s_nxt.ptr = (bus.op == IBB_OP_LOAD) ? IBB_PTR_WORD : IBB_PTR_BYTE;
				end else begin
					s_nxt.ptr = IBB_PTR_FULL; // [RULE_17]
				end
			end
			IBB_OP_ADVANCE: begin
				// Head takes next byte in even/odd order [RULE_01] [RULE_03] [RULE_09]
				s_nxt.head = s_r.ptr[0] ? s_r.odd : s_r.even;
				s_nxt.ptr = gray_dec(s_r.ptr);
			end
			IBB_OP_SEL_EVEN: begin
				s_nxt.head = s_r.even; // [RULE_19]
				s_nxt.ptr = IBB_PTR_WORD;
			end
			IBB_OP_SEL_ODD: begin
				s_nxt.head = s_r.odd; // [RULE_19]
				s_nxt.ptr = IBB_PTR_BYTE;
			end
			IBB_OP_FLUSH: s_nxt.ptr = IBB_PTR_EMPTY;
			default: s_nxt = s_r;
		endcase
	end

	// State register; pointer starts empty [RULE_21] [RULE_02]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{even: `IBB_BYTE_RST, odd: `IBB_BYTE_RST, head: `IBB_BYTE_RST,
				ptr: IBB_PTR_EMPTY};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.ptr = s_r.ptr;
	assign bus.head = s_r.head;
	assign bus.even = s_r.even;
	assign bus.odd = s_r.odd;

	// ==========================================
	// Checks
	load_feed_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
		bus.op == IBB_OP_LOAD && s_r.ptr == IBB_PTR_EMPTY
		|=> s_r.head == $past(bus.xin[15:8]) && s_r.ptr == IBB_PTR_WORD)
		else $error("empty load did not feed the head");
	load_full_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_17]
		bus.op == IBB_OP_LOAD && s_r.ptr != IBB_PTR_EMPTY
		|=> s_r.ptr == IBB_PTR_FULL && $stable(s_r.head))
		else $error("load into non-empty buffer wrong");
	gray_step_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
		bus.op == IBB_OP_ADVANCE && s_r.ptr == IBB_PTR_FULL
		|=> s_r.ptr == IBB_PTR_WORD ##0 s_r.head == $past(s_r.even))
		else $error("advance from full wrong");
	drain_fifo_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		bus.op == IBB_OP_LOAD && s_r.ptr == IBB_PTR_EMPTY ##1 bus.op == IBB_OP_ADVANCE
		|=> s_r.head == $past(bus.xin[7:0], 2) && s_r.ptr == IBB_PTR_BYTE)
		else $error("bytes not drained in order");
	full_c: cover property (@(posedge clk) disable iff (!rst_n) s_r.ptr == IBB_PTR_FULL);

endmodule
`default_nettype wire

// file: design/ibb_top.sv
// Instruction byte buffer: microcode functions, opcode dispatch, traps, AXI4-Lite regs
//
// How it works
// RULE_01: Three byte registers, even, odd and head; bytes pass head in order.
// RULE_02: A two-bit gray pointer records where valid bytes sit.
// RULE_03: At most three bytes are held, delivered first in first out.
// RULE_04: The head byte is the index of a 256-way dispatch.
// RULE_05: Dispatch is honoured only in the second cycle of a click.
// RULE_06: Dispatch with the buffer not full raises a refill trap instead.
// RULE_07: With interrupt pending, dispatch traps to interrupt instead of refill.
// RULE_08: Traps happen only at the dispatch point, never mid-instruction.
// RULE_09: Advancing read loads head from even or odd; pointer steps 2,3,1,0.
// RULE_10: Pointer low bit tells empty from non-empty; empty and full alike.
// RULE_11: Both byte reads put head on low byte, high byte zero.
// RULE_12: Hold read and nibble reads leave the pointer unchanged.
// RULE_13: Nibble reads put a head nibble on the low nibble, rest zero.
// RULE_14: A load writes high byte to even, low byte to odd register.
// RULE_15: Load into empty buffer feeds head directly and sets word state.
// RULE_16: Load with select-odd feeds the odd byte; empty goes to byte state.
// RULE_17: Load with bytes present fills holding registers only, sets full.
// RULE_18: Load together with advancing read does nothing.
// RULE_19: Select-even or select-odd alone load head and set word or byte.
// RULE_20: State-complement read drives inverted pointer onto two bus bits.
// RULE_21: Reset leaves the pointer empty so the first dispatch refills.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "ibb_defines.svh"
`default_nettype none
module ibb_top
	import ibb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`IBB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`IBB_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic click_c2,
	input wire logic opcode_dispatch,
	input wire logic forced_opcode_dispatch,
	input wire logic read_advance,
	input wire logic read_hold,
	input wire logic read_upper_nibble,
	input wire logic read_lower_nibble,
	input wire logic read_state_complement,
	input wire logic queue_load,
	input wire logic select_even,
	input wire logic select_odd,
	input wire logic [15:0] xbus_in,
	input wire logic interrupt_pending,
	output logic [15:0] xbus_out,
	output logic xbus_drive,
	output logic dispatch_go,
	output logic [7:0] dispatch_index,
	output logic refill_trap,
	output logic interrupt_trap,
	output logic buffer_nonempty
);

	typedef struct packed {
		logic aw_have;
		logic [`IBB_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic irq_force;
		logic [15:0] xout;
		logic xdrive;
		logic disp_go;
		logic [7:0] disp_idx;
		logic refill;
		logic intr;
	} ibb_top_s;

	ibb_top_s s_r;
	ibb_top_s s_nxt;

	ibb_if link ();

	ibb_core u_core (
		.clk(clk),
		.rst_n(rst_n),
		.bus(link)
	);

	// Register decode, shared by the read and write paths
	function automatic ibb_reg_e reg_decode(input logic [`IBB_ADDR_W-1:0] a);
		case (a)
			`IBB_CTRL_OFF: reg_decode = IBB_REG_CTRL;
			`IBB_STATUS_OFF: reg_decode = IBB_REG_STATUS;
			default: reg_decode = IBB_REG_NONE;
		endcase
	endfunction

	// ==========================================
	// Operation select and dispatch decision
	logic dispatch_req;
	logic trap_now;
	logic rw_clash;
	logic flush_now;
	logic irq_level;
	ibb_op_e op;

	assign irq_level = interrupt_pending | s_r.irq_force;
	// Dispatch taken only in the second click cycle [RULE_05] [RULE_08]
	assign dispatch_req = click_c2 & (opcode_dispatch | forced_opcode_dispatch);
	// Trap when the buffer is not full; forced dispatch never traps [RULE_06]
	assign trap_now = click_c2 & opcode_dispatch & ~forced_opcode_dispatch
		& (link.ptr != IBB_PTR_FULL);
	assign rw_clash = queue_load & read_advance; // [RULE_18]
	assign flush_now = s_r.aw_have & s_r.w_have & s_r.w_strb[0]
		& (reg_decode(s_r.aw_addr) == IBB_REG_CTRL) & s_r.w_data[`IBB_CTRL_FLUSH_BIT];

	// Priority: flush, clash, load, dispatch, advance, select
	always_comb begin
		op = IBB_OP_NONE;
		if (flush_now) begin
			op = IBB_OP_FLUSH;
		end else if (rw_clash) begin
			op = IBB_OP_NONE; // [RULE_18]
		end else if (queue_load) begin
			op = select_odd ? IBB_OP_LOAD_ODD : IBB_OP_LOAD; // [RULE_16]
		end else if (dispatch_req && !trap_now) begin
			op = IBB_OP_ADVANCE;
		end else if (read_advance && !dispatch_req) begin
			op = IBB_OP_ADVANCE; // [RULE_09]
		end else if (select_even) begin
			op = IBB_OP_SEL_EVEN; // [RULE_19]
		end else if (select_odd) begin
			op = IBB_OP_SEL_ODD;
		end
	end

	assign link.op = op;
	assign link.xin = xbus_in;

	// ==========================================
	// Next state: bus slave, X bus reads, dispatch outputs
	always_comb begin
		s_nxt = s_r;
		// Write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// Commit a write once both halves are held
		if (s_r.aw_have && s_r.w_have) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `IBB_RESP_OKAY;
			case (reg_decode(s_r.aw_addr))
				IBB_REG_CTRL: begin
					if (s_r.w_strb[0]) begin
						s_nxt.irq_force = s_r.w_data[`IBB_CTRL_IRQ_BIT];
					end
				end
				IBB_REG_STATUS: s_nxt.bresp = `IBB_RESP_OKAY;
				default: s_nxt.bresp = `IBB_RESP_DECERR;
			endcase
		end
		// Read channel
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `IBB_RESP_OKAY;
			s_nxt.rdata = `IBB_DATA_RST;
			case (reg_decode(s_axi_araddr))
				IBB_REG_CTRL: s_nxt.rdata[`IBB_CTRL_IRQ_BIT] = s_r.irq_force;
				IBB_REG_STATUS: begin
					s_nxt.rdata[`IBB_ST_PTR_LSB +: 2] = link.ptr;
					s_nxt.rdata[`IBB_ST_HEAD_LSB +: `IBB_BYTE_W] = link.head;
					s_nxt.rdata[`IBB_ST_EVEN_LSB +: `IBB_BYTE_W] = link.even;
					s_nxt.rdata[`IBB_ST_ODD_LSB +: `IBB_BYTE_W] = link.odd;
				end
				default: s_nxt.rresp = `IBB_RESP_DECERR;
			endcase
		end
		// X bus reads, all from the current head and pointer
		s_nxt.xout = `IBB_WORD_RST;
		s_nxt.xdrive = 1'b0;
		if (!rw_clash) begin
			if (read_advance || read_hold) begin
				s_nxt.xout[7:0] = link.head; // [RULE_11]
				s_nxt.xdrive = 1'b1;
			end else if (read_upper_nibble) begin
				s_nxt.xout[3:0] = link.head[7:4]; // [RULE_13]
				s_nxt.xdrive = 1'b1;
			end else if (read_lower_nibble) begin
				s_nxt.xout[3:0] = link.head[3:0]; // [RULE_13]
				s_nxt.xdrive = 1'b1;
			end else if (read_state_complement) begin
				s_nxt.xout[3:2] = ~link.ptr; // [RULE_20]
				s_nxt.xdrive = 1'b1;
			end
		end
		// Dispatch index is the head byte; traps replace it [RULE_04] [RULE_07]
		s_nxt.disp_go = dispatch_req & ~trap_now & ~flush_now & ~queue_load;
		s_nxt.disp_idx = link.head;
		s_nxt.refill = trap_now & ~irq_level;
		s_nxt.intr = trap_now & irq_level;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign s_axi_awready = ~s_r.aw_have & ~s_r.bvalid;
	assign s_axi_wready = ~s_r.w_have & ~s_r.bvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = ~s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign xbus_out = s_r.xout;
	assign xbus_drive = s_r.xdrive;
	assign dispatch_go = s_r.disp_go;
	assign dispatch_index = s_r.disp_idx;
	assign refill_trap = s_r.refill;
	assign interrupt_trap = s_r.intr;
	assign buffer_nonempty = link.ptr[0]; // [RULE_10]

	// ==========================================
	// Checks
	refill_trap_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
		click_c2 && opcode_dispatch && !forced_opcode_dispatch
		&& link.ptr != IBB_PTR_FULL && !irq_level
		|=> refill_trap && !dispatch_go)
		else $error("missing refill trap");
	int_priority_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
		click_c2 && opcode_dispatch && link.ptr != IBB_PTR_FULL && interrupt_pending
		&& !forced_opcode_dispatch
		|=> interrupt_trap && !refill_trap)
		else $error("interrupt trap not preferred");
	trap_point_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
		!(click_c2 && opcode_dispatch) |=> !refill_trap && !interrupt_trap)
		else $error("trap away from dispatch point");
	c2_only_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
		!click_c2 |=> !dispatch_go)
		else $error("dispatch outside second click cycle");
	disp_index_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
		click_c2 && opcode_dispatch && link.ptr == IBB_PTR_FULL && !queue_load && !flush_now
		|=> dispatch_go && dispatch_index == $past(link.head) && link.ptr == IBB_PTR_WORD)
		else $error("full dispatch wrong");
	byte_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
		read_hold && !rw_clash |=> xbus_drive && xbus_out == {8'h00, $past(link.head)})
		else $error("byte read wrong");
	nibble_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
		read_upper_nibble && !read_advance && !read_hold
		|=> xbus_out == {12'h000, $past(link.head[7:4])})
		else $error("upper nibble read wrong");
	hold_stable_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
		op == IBB_OP_NONE |=> $stable(link.ptr) && $stable(link.head))
		else $error("pointer moved without an operation");
	clash_none_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_18]
		rw_clash && !flush_now |=> $stable(link.ptr) && !xbus_drive)
		else $error("load with advancing read changed buffer");
	compl_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_20]
		read_state_complement && !read_advance && !read_hold && !read_upper_nibble
		&& !read_lower_nibble |=> xbus_out == {12'h000, ~$past(link.ptr), 2'b00})
		else $error("state complement read wrong");
	empty_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
		link.ptr == IBB_PTR_FULL |-> !buffer_nonempty)
		else $error("full not treated as empty");
	write_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.aw_have && s_r.w_have |=> s_axi_bvalid)
		else $error("write response missing");

	refill_c: cover property (@(posedge clk) disable iff (!rst_n) refill_trap);
	intr_c: cover property (@(posedge clk) disable iff (!rst_n) interrupt_trap);
	dispatch_c: cover property (@(posedge clk) disable iff (!rst_n) dispatch_go);
	clash_c: cover property (@(posedge clk) disable iff (!rst_n) rw_clash);

endmodule
`default_nettype wire

// file: dv/ibb_seq_model.sv
// Sequencer stand-in: three-cycle clicks and opcode dispatch requests
`default_nettype none
module ibb_seq_model (
	input wire logic clk,
	input wire logic rst_n,
	output logic click_c2,
	output logic opcode_dispatch,
	output logic forced_opcode_dispatch,
	input wire logic dispatch_go,
	input wire logic refill_trap,
	input wire logic interrupt_trap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase_r;

	// ==========================================
	// Click timing
	// Phase counter: 0 is c1, 1 is c2, 2 is c3
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
		end
	end

	// Second cycle of every click
	assign click_c2 = (phase_r == 2'h1);

	// No dispatch request outside a call
	initial begin
		opcode_dispatch = 1'b0;
		forced_opcode_dispatch = 1'b0;
	end

	// ==========================================
	// Dispatch request
	// Waits a stall, then raises the request for one cycle, in c2 or in c3
	task automatic dispatch(input logic forced, input logic on_c2, input int stall,
		output logic [2:0] seen);
		int n;
		repeat (stall) @(posedge clk);
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			if (phase_r == (on_c2 ? 2'h0 : 2'h1)) break;
		end
		opcode_dispatch <= !forced;
		forced_opcode_dispatch <= forced;
		@(posedge clk);
		opcode_dispatch <= 1'b0;
		forced_opcode_dispatch <= 1'b0;
		#1;
		seen = {dispatch_go, refill_trap, interrupt_trap};
	endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the instruction byte buffer
`include "ibb_defines.svh"
`default_nettype none
module tb_top
	import ibb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] F_ADV = 8'h01;
	localparam logic [7:0] F_HOLD = 8'h02;
	localparam logic [7:0] F_UP = 8'h04;
	localparam logic [7:0] F_LO = 8'h08;
	localparam logic [7:0] F_CMP = 8'h10;
	localparam logic [7:0] F_LD = 8'h20;
	localparam logic [7:0] F_SE = 8'h40;
	localparam logic [7:0] F_SO = 8'h80;
	logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, click_c2, disp, fdisp, irq;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] fn, dispatch_index;
	logic [15:0] xbus_in, xbus_out;
	logic xbus_drive, dispatch_go, refill_trap, interrupt_trap, buffer_nonempty;
	int failures, checked;

	ibb_top u_ibb_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .click_c2(click_c2), .opcode_dispatch(disp),
		.forced_opcode_dispatch(fdisp), .read_advance(fn[0]), .read_hold(fn[1]),
		.read_upper_nibble(fn[2]), .read_lower_nibble(fn[3]),
		.read_state_complement(fn[4]), .queue_load(fn[5]), .select_even(fn[6]),
		.select_odd(fn[7]), .xbus_in(xbus_in), .interrupt_pending(irq),
		.xbus_out(xbus_out), .xbus_drive(xbus_drive), .dispatch_go(dispatch_go),
		.dispatch_index(dispatch_index), .refill_trap(refill_trap),
		.interrupt_trap(interrupt_trap), .buffer_nonempty(buffer_nonempty));

	ibb_seq_model u_ibb_seq_model (.clk(clk), .rst_n(rst_n), .click_c2(click_c2),
		.opcode_dispatch(disp), .forced_opcode_dispatch(fdisp),
		.dispatch_go(dispatch_go), .refill_trap(refill_trap),
		.interrupt_trap(interrupt_trap));

	// ==========================================
	// Checking and reporting
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Ends the run when a handshake never came
	task automatic guard(input int n);
		if (n >= 50) begin
			failures++;
			$display("[ERR] handshake expected answer seen timeout");
			final_report();
		end
	endtask

	// ==========================================
	// Register bus master
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		int n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !(aw_ok && w_ok); n++) begin
			@(posedge clk);
			if (awready && !aw_ok) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		guard(n);
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (bvalid) break;
		end
		bready <= 1'b0;
		guard(n);
		chk("write response", 32'(er), 32'(bresp));
	endtask

	task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) break;
		end
		arvalid <= 1'b0;
		guard(n);
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (rvalid) break;
		end
		rready <= 1'b0;
		guard(n);
		d = rdata;
		chk("read response", 32'(er), 32'(rresp));
	endtask

	// Reads status and compares pointer, and head when asked
	task automatic chk_st(input string what, input logic [1:0] p, input logic [7:0] h,
		input bit hv, output logic [31:0] d);
		axi_rd(`IBB_STATUS_OFF, `IBB_RESP_OKAY, d);
		chk({what, " pointer"}, 32'(p), 32'(d[`IBB_ST_PTR_LSB +: 2]));
		if (hv) begin
			chk({what, " head"}, 32'(h), 32'(d[`IBB_ST_HEAD_LSB +: 8]));
		end
	endtask

	task automatic flush();
		axi_wr(`IBB_CTRL_OFF, 32'h1 << `IBB_CTRL_FLUSH_BIT, `IBB_RESP_OKAY);
	endtask

	// One microcode function for one cycle; outputs are settled on return
	task automatic op(input logic [7:0] f, input logic [15:0] x);
		@(posedge clk);
		fn <= f;
		xbus_in <= x;
		@(posedge clk);
		fn <= 8'h00;
		#1;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [31:0] d;
		chk_st("reset", IBB_PTR_EMPTY, 8'h00, 1, d);
		chk("reset nonempty", 32'h0, 32'(buffer_nonempty));
		axi_rd(4'h8, `IBB_RESP_DECERR, d);
		chk("unmapped data", 32'h0, d);
		$display("Test reset done");
	endtask

	task automatic t_fifo();
		logic [31:0] d;
		op(F_LD, 16'hAABB);
		chk("load drive", 32'h0, 32'(xbus_drive));
		chk_st("load empty", IBB_PTR_WORD, 8'hAA, 1, d);
		op(F_ADV, 16'h0000);
		chk("advance data", 32'h00AA, 32'(xbus_out));
		chk("advance drive", 32'h1, 32'(xbus_drive));
		chk_st("advance", IBB_PTR_BYTE, 8'hBB, 1, d);
		chk("byte nonempty", 32'h1, 32'(buffer_nonempty));
		op(F_CMP, 16'h0000);
		chk("complement", 32'h0008, 32'(xbus_out));
		op(F_ADV, 16'h0000);
		chk("last byte", 32'h00BB, 32'(xbus_out));
		chk_st("drained", IBB_PTR_EMPTY, 8'h00, 0, d);
		chk("empty nonempty", 32'h0, 32'(buffer_nonempty));
		// Load into empty, then advance in the very next cycle
		@(posedge clk);
		fn <= F_LD;
		xbus_in <= 16'h5A6B;
		op(F_ADV, 16'h0000);
		chk("back to back", 32'h005A, 32'(xbus_out));
		chk_st("back to back", IBB_PTR_BYTE, 8'h6B, 1, d);
		$display("Test fifo done");
	endtask

	task automatic t_full();
		logic [31:0] d;
		flush();
		op(F_LD, 16'h1122);
		op(F_LD, 16'h3344);
		chk_st("second load", IBB_PTR_FULL, 8'h11, 1, d);
		chk("holding", 32'h4433, 32'(d[`IBB_ST_EVEN_LSB +: 16]));
		chk("full nonempty", 32'h0, 32'(buffer_nonempty));
		op(F_LD | F_ADV, 16'h5566);
		chk("clash drive", 32'h0, 32'(xbus_drive));
		chk_st("clash", IBB_PTR_FULL, 8'h11, 1, d);
		op(F_ADV, 16'h0000);
		chk("full advance", 32'h0011, 32'(xbus_out));
		chk_st("full advance", IBB_PTR_WORD, 8'h00, 0, d);
		$display("Test full done");
	endtask

	task automatic t_reads();
		logic [31:0] d;
		logic [7:0] f[3] = '{F_UP, F_LO, F_HOLD};
		logic [15:0] e[3] = '{16'h000A, 16'h0005, 16'h00A5};
		flush();
		op(F_LD, 16'hA5C3);
		for (int i = 0; i < 3; i++) begin
			op(f[i], 16'h0000);
			chk("read data", 32'(e[i]), 32'(xbus_out));
		end
		chk_st("reads", IBB_PTR_WORD, 8'hA5, 1, d);
		$display("Test reads done");
	endtask

	task automatic t_select();
		logic [31:0] d;
		flush();
		op(F_LD | F_SO, 16'h1234);
		chk_st("load odd", IBB_PTR_BYTE, 8'h34, 1, d);
		op(F_SE, 16'h0000);
		chk_st("select even", IBB_PTR_WORD, 8'h12, 1, d);
		op(F_SO, 16'h0000);
		chk_st("select odd", IBB_PTR_BYTE, 8'h34, 1, d);
		$display("Test select done");
	endtask

	task automatic t_dispatch();
		logic [2:0] s;
		logic [31:0] d;
		flush();
		u_ibb_seq_model.dispatch(1'b0, 1'b1, 0, s);
		chk("empty dispatch", 32'h2, 32'(s));
		@(posedge clk);
		irq <= 1'b1;
		u_ibb_seq_model.dispatch(1'b0, 1'b1, 1, s);
		chk("pending dispatch", 32'h1, 32'(s));
		@(posedge clk);
		irq <= 1'b0;
		axi_wr(`IBB_CTRL_OFF, 32'h3, `IBB_RESP_OKAY);
		axi_rd(`IBB_CTRL_OFF, `IBB_RESP_OKAY, d);
		chk("control", 32'h1, d);
		u_ibb_seq_model.dispatch(1'b0, 1'b1, 0, s);
		chk("forced irq dispatch", 32'h1, 32'(s));
		axi_wr(`IBB_CTRL_OFF, 32'h0, `IBB_RESP_OKAY);
		u_ibb_seq_model.dispatch(1'b0, 1'b0, 0, s);
		chk("dispatch off c2", 32'h0, 32'(s));
		op(F_LD, 16'hC7D8);
		op(F_LD, 16'hE9F0);
		u_ibb_seq_model.dispatch(1'b0, 1'b1, 2, s);
		chk("full dispatch", 32'h4, 32'(s));
		chk("dispatch index", 32'hC7, 32'(dispatch_index));
		chk_st("after dispatch", IBB_PTR_WORD, 8'hE9, 1, d);
		u_ibb_seq_model.dispatch(1'b1, 1'b1, 0, s);
		chk("always dispatch", 32'h4, 32'(s));
		chk("always index", 32'hE9, 32'(dispatch_index));
		$display("Test dispatch done");
	endtask

	// ==========================================
	// Clock and main sequence
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, irq} = '0;
		{awaddr, araddr, wstrb, wdata, fn, xbus_in} = '0;
		failures = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_fifo();
		t_full();
		t_reads();
		t_select();
		t_dispatch();
		final_report();
	end
endmodule
`default_nettype wire
